// [hdl/dgp_pkg.sv]
// Constants and carrier types for the gain, offset and pattern check bank
package dgp_pkg;

  // Register byte offsets on the control port
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_Q_OFF2 = 12'h13b;
  localparam logic [11:0] OFF_I_GAIN_LO = 12'h13c;
  localparam logic [11:0] OFF_I_GAIN_HI = 12'h13d;
  localparam logic [11:0] OFF_Q_GAIN_LO = 12'h13e;
  localparam logic [11:0] OFF_Q_GAIN_HI = 12'h13f;
  localparam logic [11:0] OFF_UP_LO = 12'h140;
  localparam logic [11:0] OFF_UP_HI = 12'h141;
  localparam logic [11:0] OFF_DOWN_LO = 12'h142;
  localparam logic [11:0] OFF_DOWN_HI = 12'h143;
  localparam logic [11:0] OFF_STARTUP = 12'h146;
  localparam logic [11:0] OFF_ROT_CTRL = 12'h147;
  localparam logic [11:0] OFF_CHK_CTRL = 12'h14b;
  localparam logic [11:0] OFF_ERR_REAL = 12'h14c;
  localparam logic [11:0] OFF_ERR_IMAG = 12'h14d;

  // Field positions inside the pattern check and rotate control bytes
  localparam int POS_GOOD_IMAG = 7;
  localparam int POS_GOOD_REAL = 6;
  localparam int POS_CHK_RSVD = 3;
  localparam int POS_POLY_SEL = 2;
  localparam int POS_CNT_CLEAR = 1;
  localparam int POS_CHK_EN = 0;
  localparam int POS_ROT_FORCE = 6;

  // Reset values
  localparam logic [4:0] RST_Q_OFF2 = 5'h00;
  localparam logic [7:0] RST_GAIN_LO = 8'h00;
  localparam logic [3:0] RST_GAIN_HI = 4'h8;
  localparam logic [7:0] RST_UP_LO = 8'h04;
  localparam logic [3:0] RST_UP_HI = 4'h0;
  localparam logic [7:0] RST_DOWN_LO = 8'h09;
  localparam logic [3:0] RST_DOWN_HI = 4'h0;
  localparam logic [7:0] RST_STARTUP = 8'h00;
  localparam logic [7:0] RST_ROT_CTRL = 8'h00;
  localparam logic [7:0] RST_CHK_CTRL = 8'h08;
  localparam logic [7:0] RST_ERR_CNT = 8'h00;

  // Checker counts
  localparam logic [3:0] SEED_BITS = 4'hf;
  localparam logic [7:0] ERR_CNT_MAX = 8'hff;

  // Control port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dgp_req_t;

  // One pattern bit per channel per valid cycle
  typedef struct packed {
    logic valid;
    logic real_bit;
    logic imag_bit;
  } dgp_lane_in_t;

  // Gain settings toward the datapath
  typedef struct packed {
    logic [11:0] i_gain;
    logic [11:0] q_gain;
    logic [11:0] up_step;
    logic [11:0] down_step;
  } dgp_gain_t;

  // Register bank state
  typedef struct packed {
    logic [4:0] q_off2;
    logic [11:0] i_gain;
    logic [11:0] q_gain;
    logic [11:0] up_step;
    logic [11:0] down_step;
    logic [7:0] startup;
    logic [1:0] rot_force;
    logic [5:0] rot_rsvd;
    logic [1:0] chk_rsvd;
    logic poly_sel;
    logic cnt_clear;
    logic chk_en;
    logic [4:0] q_off_app;
    logic [7:0] rdata;
  } dgp_regs_t;

  // Lane checker state
  typedef struct packed {
    logic [14:0] shift;
    logic [3:0] fill;
    logic good;
    logic [7:0] count;
  } dgp_lane_t;

endpackage : dgp_pkg

// [hdl/dgp_lane_check.sv]
// Self-synchronising pattern checker for one channel
module dgp_lane_check
  import dgp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic enable, // Checker enable level
  input wire logic poly_sel, // 0 short poly, 1 long poly
  input wire logic clear, // Error counter clear level
  input wire logic bit_valid, // Pattern bit valid
  input wire logic bit_in, // Received pattern bit
  output logic good, // Last checked bit matched
  output logic [7:0] count // Saturating error count
);

  dgp_lane_t s;
  dgp_lane_t next_s;
  logic predicted;
  logic seeded;

  // Next bit from the previous received bits, taps per polynomial
  always_comb
  begin
    predicted = poly_sel ? (s.shift[14] ^ s.shift[13])
                         : (s.shift[6] ^ s.shift[5]);
    seeded = (s.fill == SEED_BITS);
  end

  // Checker next state; disabled checker forgets its seed
  always_comb
  begin
    next_s = s;
    if (!enable)
    begin
      next_s.fill = '0;
      next_s.good = 1'b0;
    end
    else if (bit_valid)
    begin
      next_s.shift = {s.shift[13:0], bit_in};
      if (!seeded)
        next_s.fill = s.fill + 4'h1;
      else
      begin
        next_s.good = (predicted == bit_in);
        if (predicted != bit_in && s.count != ERR_CNT_MAX)
          next_s.count = s.count + 8'h01;
      end
    end
    // Clear wins over counting so a held clear pins the count
    if (clear)
      next_s.count = RST_ERR_CNT;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign good = s.good;
  assign count = s.count;

  // Held clear keeps the count at zero
  clear_zero_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    clear |=> count == 8'h00)
    else $error("count not cleared");

  // Count sticks at its top value
  count_sat_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (count == 8'hff && !clear) |=> count == 8'hff)
    else $error("count wrapped");

  // Counter frozen while disabled
  count_hold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!enable && !clear) |=> $stable(count))
    else $error("count moved while disabled");

  // Matching bit after seeding raises good
  good_set_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (enable && bit_valid && seeded && predicted == bit_in) |=> good)
    else $error("good not set on match");

endmodule : dgp_lane_check

// [hdl/dgp_bank.sv]
// Gain, offset and pattern check register bank of the datapath

// Operation
// - Q offset part two, five bits, top zero
// - I gain is low byte plus four-bit high
// - Q gain is low byte plus four-bit high
// - Ramp-up step twelve bits, resets to four
// - Ramp-down step twelve bits, resets to nine
// - Bit seven reports imaginary pattern good
// - Bit six real good; checker runs when enabled
// - Good flag set on correct sequence
// - Counter clear bit holds both counters zero
// - Real error count readable, resets zero
// - Imaginary error count readable, resets zero
// - Offset applied only while module enabled
module dgp_bank
  import dgp_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz
  input wire logic rst_b, // Async reset, active low
  input dgp_req_t req, // Control port access
  output logic [7:0] rdata, // Read data, one cycle after rd
  input wire logic offset_module_enable, // DC offset module enable
  input dgp_lane_in_t lane_in, // Pattern bits for both channels
  output dgp_gain_t gain, // Gain and ramp steps
  output logic [4:0] q_offset_applied, // Gated Q offset part two
  output logic [7:0] startup_config, // Startup configuration byte
  output logic [1:0] rotate_request_force // Forced rotate request
);

  localparam dgp_regs_t REGS_RST = '{
    q_off2: RST_Q_OFF2,
    i_gain: {RST_GAIN_HI, RST_GAIN_LO},
    q_gain: {RST_GAIN_HI, RST_GAIN_LO},
    up_step: {RST_UP_HI, RST_UP_LO},
    down_step: {RST_DOWN_HI, RST_DOWN_LO},
    startup: RST_STARTUP,
    rot_force: RST_ROT_CTRL[POS_ROT_FORCE +: 2],
    rot_rsvd: RST_ROT_CTRL[5:0],
    chk_rsvd: RST_CHK_CTRL[POS_CHK_RSVD +: 2],
    poly_sel: RST_CHK_CTRL[POS_POLY_SEL],
    cnt_clear: RST_CHK_CTRL[POS_CNT_CLEAR],
    chk_en: RST_CHK_CTRL[POS_CHK_EN],
    q_off_app: RST_Q_OFF2,
    rdata: 8'h00
  };

  dgp_regs_t s;
  dgp_regs_t next_s;
  logic [1:0] lane_good;
  logic [7:0] lane_count [2];
  logic [7:0] read_val;

  // Address match, shared by write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  // Channel 0 real, channel 1 imaginary
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_lane
      dgp_lane_check u_chk (
        .clk(clk),
        .rst_b(rst_b),
        .enable(s.chk_en),
        .poly_sel(s.poly_sel),
        .clear(s.cnt_clear),
        .bit_valid(lane_in.valid),
        .bit_in(g == 0 ? lane_in.real_bit : lane_in.imag_bit),
        .good(lane_good[g]),
        .count(lane_count[g])
      );
    end
  endgenerate

  // Read mux; reserved bits that are read-only come back as zero
  always_comb
  begin
    read_val = 8'h00;
    if (hit(req.addr, OFF_Q_OFF2))
      read_val = {3'b000, s.q_off2};
    else if (hit(req.addr, OFF_I_GAIN_LO))
      read_val = s.i_gain[7:0];
    else if (hit(req.addr, OFF_I_GAIN_HI))
      read_val = {4'h0, s.i_gain[11:8]};
    else if (hit(req.addr, OFF_Q_GAIN_LO))
      read_val = s.q_gain[7:0];
    else if (hit(req.addr, OFF_Q_GAIN_HI))
      read_val = {4'h0, s.q_gain[11:8]};
    else if (hit(req.addr, OFF_UP_LO))
      read_val = s.up_step[7:0];
    else if (hit(req.addr, OFF_UP_HI))
      read_val = {4'h0, s.up_step[11:8]};
    else if (hit(req.addr, OFF_DOWN_LO))
      read_val = s.down_step[7:0];
    else if (hit(req.addr, OFF_DOWN_HI))
      read_val = {4'h0, s.down_step[11:8]};
    else if (hit(req.addr, OFF_STARTUP))
      read_val = s.startup;
    else if (hit(req.addr, OFF_ROT_CTRL))
      read_val = {s.rot_force, s.rot_rsvd};
    else if (hit(req.addr, OFF_CHK_CTRL))
      read_val = {lane_good[1], lane_good[0], 1'b0, s.chk_rsvd,
                  s.poly_sel, s.cnt_clear, s.chk_en};
    else if (hit(req.addr, OFF_ERR_REAL))
      read_val = lane_count[0];
    else if (hit(req.addr, OFF_ERR_IMAG))
      read_val = lane_count[1];
  end

  // Register writes; good flags and counts ignore writes
  always_comb
  begin
    next_s = s;
    if (req.wr)
    begin
      if (hit(req.addr, OFF_Q_OFF2))
        next_s.q_off2 = req.wdata[4:0];
      if (hit(req.addr, OFF_I_GAIN_LO))
        next_s.i_gain[7:0] = req.wdata;
      if (hit(req.addr, OFF_I_GAIN_HI))
        next_s.i_gain[11:8] = req.wdata[3:0];
      if (hit(req.addr, OFF_Q_GAIN_LO))
        next_s.q_gain[7:0] = req.wdata;
      if (hit(req.addr, OFF_Q_GAIN_HI))
        next_s.q_gain[11:8] = req.wdata[3:0];
      if (hit(req.addr, OFF_UP_LO))
        next_s.up_step[7:0] = req.wdata;
      if (hit(req.addr, OFF_UP_HI))
        next_s.up_step[11:8] = req.wdata[3:0];
      if (hit(req.addr, OFF_DOWN_LO))
        next_s.down_step[7:0] = req.wdata;
      if (hit(req.addr, OFF_DOWN_HI))
        next_s.down_step[11:8] = req.wdata[3:0];
      // Stored as written; the host is expected to load one here
      if (hit(req.addr, OFF_STARTUP))
        next_s.startup = req.wdata;
      if (hit(req.addr, OFF_ROT_CTRL))
      begin
        next_s.rot_force = req.wdata[POS_ROT_FORCE +: 2];
        next_s.rot_rsvd = req.wdata[5:0];
      end
      if (hit(req.addr, OFF_CHK_CTRL))
      begin
        next_s.chk_rsvd = req.wdata[POS_CHK_RSVD +: 2];
        next_s.poly_sel = req.wdata[POS_POLY_SEL];
        next_s.cnt_clear = req.wdata[POS_CNT_CLEAR];
        next_s.chk_en = req.wdata[POS_CHK_EN];
      end
    end
    // Offset reaches the datapath only while the module is on
    next_s.q_off_app = offset_module_enable ? s.q_off2 : 5'h00;
    // Read data is captured so the port sees a flop, one cycle late
    if (req.rd)
      next_s.rdata = read_val;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= REGS_RST;
    else
      s <= next_s;
  end

  // Outputs straight from state flops
  assign rdata = s.rdata;
  assign gain = '{i_gain: s.i_gain, q_gain: s.q_gain,
                  up_step: s.up_step, down_step: s.down_step};
  assign q_offset_applied = s.q_off_app;
  assign startup_config = s.startup;
  assign rotate_request_force = s.rot_force;

  // Write to a given offset
  sequence wr_at(logic [ADDR_W-1:0] off);
    req.wr && req.addr == off;
  endsequence

  // Read from a given offset
  sequence rd_at(logic [ADDR_W-1:0] off);
    req.rd && req.addr == off;
  endsequence

  // Offset write, then a cycle with the offset module on
  sequence off_wr_then_on;
    wr_at(OFF_Q_OFF2) ##1 offset_module_enable;
  endsequence

  // Count write while the counter cannot move by itself
  sequence err_wr_idle(logic [ADDR_W-1:0] off);
    req.wr && req.addr == off && !s.chk_en && !s.cnt_clear;
  endsequence

  // Offset part two reads back with zero top bits
  q_off_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_Q_OFF2) |=> rdata == {3'b000, $past(s.q_off2)})
    else $error("offset readback wrong");

  // A written offset reaches the datapath once the module is on
  q_off_wr_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    off_wr_then_on |=> q_offset_applied == $past(req.wdata[4:0], 2))
    else $error("written offset not applied");

  // I gain low write keeps the high nibble
  i_gain_lo_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_I_GAIN_LO) |=> gain.i_gain ==
      {$past(s.i_gain[11:8]), $past(req.wdata)})
    else $error("i gain low write wrong");

  // I gain high write lands in the top nibble only
  i_gain_hi_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_I_GAIN_HI) |=> gain.i_gain ==
      {$past(req.wdata[3:0]), $past(s.i_gain[7:0])})
    else $error("i gain high write wrong");

  // I gain high read shows a bare nibble
  i_gain_rd_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_I_GAIN_HI) |=> rdata == {4'h0, $past(s.i_gain[11:8])})
    else $error("i gain readback wrong");

  // Q gain low write keeps the high nibble
  q_gain_lo_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_Q_GAIN_LO) |=> gain.q_gain ==
      {$past(s.q_gain[11:8]), $past(req.wdata)})
    else $error("q gain low write wrong");

  // Q gain high write lands in the top nibble only
  q_gain_hi_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_Q_GAIN_HI) |=> gain.q_gain ==
      {$past(req.wdata[3:0]), $past(s.q_gain[7:0])})
    else $error("q gain high write wrong");

  // Ramp-up low write keeps its high nibble
  up_step_lo_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_UP_LO) |=> gain.up_step ==
      {$past(s.up_step[11:8]), $past(req.wdata)})
    else $error("ramp up write wrong");

  // Ramp-up high write keeps its low byte
  up_step_hi_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_UP_HI) |=> gain.up_step ==
      {$past(req.wdata[3:0]), $past(s.up_step[7:0])})
    else $error("ramp up high write wrong");

  // Ramp-down low write keeps its high nibble
  down_step_lo_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_DOWN_LO) |=> gain.down_step ==
      {$past(s.down_step[11:8]), $past(req.wdata)})
    else $error("ramp down low write wrong");

  // Ramp-down high write keeps its low byte
  down_step_hi_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_DOWN_HI) |=> gain.down_step ==
      {$past(req.wdata[3:0]), $past(s.down_step[7:0])})
    else $error("ramp down high write wrong");

  // Ramp-down high read shows a bare nibble
  down_step_rd_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_DOWN_HI) |=> rdata == {4'h0, $past(s.down_step[11:8])})
    else $error("ramp down readback wrong");

  // Disabled offset module applies zero on the next edge
  offset_gate_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !offset_module_enable |=> q_offset_applied == 5'h00)
    else $error("offset applied while off");

  // Enabled offset module passes the stored offset through
  offset_pass_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    offset_module_enable |=> q_offset_applied == $past(s.q_off2))
    else $error("offset not passed while on");

  // Control write sets mode, clear and enable together
  chk_ctrl_wr_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_CHK_CTRL) |=> {s.poly_sel, s.cnt_clear, s.chk_en} ==
      $past(req.wdata[2:0]))
    else $error("checker control write wrong");

  // Control read returns the stored low five bits
  chk_ctrl_rd_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_CHK_CTRL) |=> rdata[4:0] ==
      $past({s.chk_rsvd, s.poly_sel, s.cnt_clear, s.chk_en}))
    else $error("checker control readback wrong");

  // Status byte carries both good flags
  good_flags_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_CHK_CTRL) |=> rdata[7:6] == $past(lane_good)
      && rdata[5] == 1'b0)
    else $error("good flags readback wrong");

  // A disabled checker reports no good data on either lane
  good_drop_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.chk_en |=> lane_good == 2'b00)
    else $error("good flag kept while disabled");

  // Counter clear pins both lanes at zero
  clear_both_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.cnt_clear |=> lane_count[0] == 8'h00 && lane_count[1] == 8'h00)
    else $error("counts not held at zero");

  // Real count register reads its counter
  err_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_ERR_REAL) |=> rdata == $past(lane_count[0]))
    else $error("real count readback wrong");

  // Imaginary count register reads its counter
  err_imag_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    rd_at(OFF_ERR_IMAG) |=> rdata == $past(lane_count[1]))
    else $error("imag count readback wrong");

  // Writes cannot load the read-only real count
  err_wr_real_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    err_wr_idle(OFF_ERR_REAL) |=> $stable(lane_count[0]))
    else $error("real count took a write");

  // Writes cannot load the read-only imaginary count
  err_wr_imag_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    err_wr_idle(OFF_ERR_IMAG) |=> $stable(lane_count[1]))
    else $error("imag count took a write");

  // Startup byte write is visible on the next edge
  startup_wr_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_at(OFF_STARTUP) |=> startup_config == $past(req.wdata))
    else $error("startup byte not stored");

endmodule : dgp_bank

// [verification/tb_top.sv]
// Self-checking bench for the gain, offset and pattern check bank
module tb_top
  import dgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic off_en = 1'b0;
  dgp_req_t req = '0;
  dgp_lane_in_t lane_in = '0;
  logic [7:0] rdata;
  dgp_gain_t gain;
  logic [4:0] q_app;
  logic [7:0] start_cfg;
  logic [1:0] rot_f;
  int n_fail = 0;
  int tests_run = 0;
  int seed = 51091;
  logic [7:0] exp_q [$];
  logic rd_pend = 1'b0;
  logic [7:0] d;
  // Bench model of both checker lanes
  logic [14:0] hist [2] = '{15'h0000, 15'h0000};
  int fill [2] = '{0, 0};
  logic good [2] = '{1'b0, 1'b0};
  logic [7:0] cnt [2] = '{8'h00, 8'h00};
  logic ctl_en = 1'b0;
  logic ctl_poly = 1'b0;
  logic ctl_clr = 1'b0;
  // Register table: offset, reset value, readable mask; last is unmapped
  localparam logic [11:0] reg_off [14] = '{OFF_Q_OFF2, OFF_I_GAIN_LO,
    OFF_I_GAIN_HI, OFF_Q_GAIN_LO, OFF_Q_GAIN_HI, OFF_UP_LO, OFF_UP_HI,
    OFF_DOWN_LO, OFF_DOWN_HI, OFF_STARTUP, OFF_ROT_CTRL, OFF_ERR_REAL,
    OFF_ERR_IMAG, 12'h144};
  localparam logic [7:0] reg_rst [14] = '{8'h00, 8'h00, 8'h08, 8'h00,
    8'h08, 8'h04, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] reg_msk [14] = '{8'h1f, 8'hff, 8'h0f, 8'hff,
    8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [14];

  // 25 MHz system clock
  always #20 clk = ~clk;

  dgp_bank DUT (
    .clk(clk),
    .rst_b(rst_b),
    .req(req),
    .rdata(rdata),
    .offset_module_enable(off_en),
    .lane_in(lane_in),
    .gain(gain),
    .q_offset_applied(q_app),
    .startup_config(start_cfg),
    .rotate_request_force(rot_f)
  );

  task tally_and_finish;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_rd(input logic [7:0] got, input logic [7:0] exp);
    chk(12'(got), 12'(exp));
  endtask : chk_rd

  // Read data is settled by mid-cycle after the taking edge
  always @(posedge clk)
    rd_pend <= req.rd & rst_b;
  always @(negedge clk)
    if (rd_pend)
      chk_rd(rdata, exp_q.pop_front());

  // One access; lane valid drops so no bit slips in unmodelled
  task xfer(input logic [11:0] a, input logic [7:0] dat, input logic w);
    @(posedge clk);
    req <= '{addr: a, wdata: dat, wr: w, rd: !w};
    lane_in.valid <= 1'b0;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask : xfer

  task wr(input logic [11:0] a, input logic [7:0] dat);
    xfer(a, dat, 1'b1);
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(a, 8'h00, 1'b0);
  endtask : rd

  // Outputs toward the datapath against the written shadow
  task chk_out;
    @(negedge clk);
    chk(gain.i_gain, {wv[2][3:0], wv[1]});
    chk(gain.q_gain, {wv[4][3:0], wv[3]});
    chk(gain.up_step, {wv[6][3:0], wv[5]});
    chk(gain.down_step, {wv[8][3:0], wv[7]});
    chk(12'(start_cfg), 12'(wv[9]));
    chk(12'(rot_f), 12'(wv[10][7:6]));
    chk(12'(q_app), off_en ? 12'(wv[0][4:0]) : 12'h000);
  endtask : chk_out

  function automatic logic pred(input int l);
    return ctl_poly ? hist[l][13] ^ hist[l][14] : hist[l][5] ^ hist[l][6];
  endfunction : pred

  // One bit per lane; once seeded, bits follow the sequence unless flipped or raw
  task send(input logic [1:0] flip, input logic raw);
    logic [1:0] b;
    b = 2'($random(seed));
    @(posedge clk);
    for (int l = 0; l < 2; l++)
    begin
      if (ctl_en)
      begin
        if (fill[l] < 15)
          fill[l]++;
        else
        begin
          if (!raw)
            b[l] = pred(l) ^ flip[l];
          good[l] = (b[l] == pred(l));
          if (!good[l] && !ctl_clr && cnt[l] != 8'hff)
            cnt[l]++;
        end
        hist[l] = {hist[l][13:0], b[l]};
      end
    end
    lane_in <= '{1'b1, b[0], b[1]};
  endtask : send

  // Disabling loses the seed and the good flags; clear zeroes counts
  task ctl(input logic en, input logic poly, input logic clr);
    ctl_en = en;
    ctl_poly = poly;
    ctl_clr = clr;
    if (!en)
    begin
      fill = '{0, 0};
      good = '{1'b0, 1'b0};
    end
    if (clr)
      cnt = '{8'h00, 8'h00};
    wr(OFF_CHK_CTRL, {5'b00001, poly, clr, en});
  endtask : ctl

  task chk_pat;
    @(posedge clk);
    lane_in.valid <= 1'b0;
    @(posedge clk);
    rd(OFF_CHK_CTRL, {good[1], good[0], 3'b001, ctl_poly, ctl_clr, ctl_en});
    rd(OFF_ERR_REAL, cnt[0]);
    rd(OFF_ERR_IMAG, cnt[1]);
  endtask : chk_pat

  // Watchdog: the run needs about a thousand cycles
  initial
  begin
    #(40 * 20000);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    wv = reg_rst;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 14; k++)
      rd(reg_off[k], reg_rst[k]);
    rd(OFF_CHK_CTRL, 8'h08);
    chk_out();
    wr(OFF_STARTUP, 8'h01);
    wv[9] = 8'h01;
    chk_out();
    // Random writes to every table place, check control aside; read-only and unmapped places keep zero
    for (int k = 0; k < 14; k++)
    begin
      d = 8'($random(seed));
      wr(reg_off[k], d);
      wv[k] = d;
      rd(reg_off[k], d & reg_msk[k]);
    end
    chk_out();
    @(posedge clk);
    off_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out();
    // Both polynomials; real lane takes random single-bit errors
    for (int m = 0; m < 2; m++)
    begin
      ctl(1'b1, m[0], 1'b0);
      repeat (75) send({1'b0, ($random(seed) & 7) == 0}, 1'b0);
      chk_pat();
      ctl(1'b0, m[0], 1'b0);
      repeat (5) send(2'b11, 1'b1);
      chk_pat();
    end
    // Garbage on both lanes drives the counts into saturation
    ctl(1'b1, 1'b0, 1'b0);
    repeat (700) send(2'b00, 1'b1);
    chk_pat();
    ctl(1'b1, 1'b0, 1'b1);
    repeat (20) send(2'b00, 1'b1);
    chk_pat();
    ctl(1'b1, 1'b0, 1'b0);
    repeat (40) send(2'b00, 1'b1);
    chk_pat();
    repeat (2) @(posedge clk);
    tally_and_finish();
  end

endmodule : tb_top
